//--- verilog/idx_port_pkg.sv
// Constants and types shared by the index port device and host ends.
package idx_port_pkg;

   // I/O port pair and index field layout.
   localparam logic [15:0] INDEX_PORT_ADDR = 16'h03e0;
   localparam logic [15:0] DATA_PORT_ADDR  = 16'h03e1;
   localparam int          DEV_BIT_POS     = 7;
   localparam int          SLOT_BIT_POS    = 6;
   localparam int          REG_NUM_MSB     = 5;
   localparam logic [5:0]  REGS_PER_SLOT   = 6'h38;
   localparam int          MEM_DEPTH       = 112;

   // Strap pin positions in the strap vector.
   localparam int IRQ_STRAP  = 0;
   localparam int SPK_STRAP  = 1;
   localparam int RING_STRAP = 2;

   // Level the device drives on its strap pins once out of bus reset.
   localparam logic [2:0] PIN_IDLE = 3'h7;

   // Bus cycle timing.
   localparam int         CLK_PERIOD_NS = 10;
   localparam int         IO_STROBE_NS  = 30;
   localparam logic [3:0] IO_STROBE_CYC =
      4'((IO_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Host register offsets on APB.
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] ADDR_OFS   = 8'h04;
   localparam logic [7:0] RESULT_OFS = 8'h08;
   localparam logic [7:0] STRAP_OFS  = 8'h0c;

   // Host register fields.
   localparam int GO_BIT    = 0;
   localparam int WR_BIT    = 1;
   localparam int PD_BIT    = 2;
   localparam int BRST_BIT  = 3;
   localparam int EXT_BIT   = 4;
   localparam int WDATA_LSB = 8;
   localparam int FLOAT_BIT = 8;
   localparam int BUSY_BIT  = 16;

   // Host register reset values.
   localparam logic [15:0] ADDR_RST  = 16'h03e0;
   localparam logic [2:0]  STRAP_RST = 3'h7;
   localparam logic        BRST_RST  = 1'h1;

   typedef enum {H_IDLE, H_SETUP, H_STROBE, H_HOLD} host_state_t;

endpackage

//--- verilog/isa_io_if.sv
// Host I/O bus between the index port device and its host.
`timescale 1ns/1ps
interface isa_io_if;
   logic [15:0] sa;
   logic        aen;
   logic        iord_n;
   logic        iowr_n;
   logic        cs_n;
   logic        host_bus_reset;
   logic [7:0]  host_sd_o;
   logic        host_sd_oe_n;
   logic [7:0]  dev_sd_o;
   logic        dev_sd_oe_n;
   logic [7:0]  sd;
   logic        sd_driven;
   logic [2:0]  strap_o;
   logic [2:0]  strap_oe_n;
   logic [2:0]  strap_pull;
   logic [2:0]  strap_pin;

   // Resolved data bus; an undriven bus reads as all ones.
   assign sd = !dev_sd_oe_n ? dev_sd_o :
               (!host_sd_oe_n ? host_sd_o : 8'hff);
   assign sd_driven = !dev_sd_oe_n || !host_sd_oe_n;

   // Weak board pulls win only while the device releases a pin.
   assign strap_pin = (strap_oe_n & strap_pull) | (~strap_oe_n & strap_o);

   modport dev (
      input  sa, aen, iord_n, iowr_n, cs_n, host_bus_reset, sd,
      input  strap_pin,
      output dev_sd_o, dev_sd_oe_n, strap_o, strap_oe_n
   );

   modport host (
      output sa, aen, iord_n, iowr_n, cs_n, host_bus_reset,
      output host_sd_o, host_sd_oe_n, strap_pull,
      input  sd, sd_driven
   );
endinterface

//--- verilog/edge_pulse.sv
// Edge detector giving one-cycle pulses on a same-clock level.
`timescale 1ns/1ps
module edge_pulse #(
   parameter logic INIT = 1'h1
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic level,
   output logic      fell,
   output logic      rose
);
   logic prev_ff;
   logic nxt_prev;

   // Previous level, reset to the idle level so no edge shows at start.
   always_comb begin
      nxt_prev = level;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_ff <= INIT;
      end else begin
         prev_ff <= nxt_prev;
      end
   end

   assign fell = prev_ff & ~level;
   assign rose = ~prev_ff & level;
endmodule // edge_pulse

//--- verilog/idx_port_device.sv
// Device end: indexed control register access through two I/O ports.
//
// Function
// - Eight-bit registers reached through index, data ports.
// - External mode: chip select alone marks access.
// - Bus reset fall: irq strap picks decode.
// - Board strap is a weak pull.
// - Host holds chip select low except power-down, external-mode misses.
// - Index bit7 device, bit6 slot, rest register.
// - Fifty-six registers for each card slot.
// - Device bit latched from speaker or ring strap.
// - One-slot variant latches slot bit from speaker.
// - Strap high latches zero, low latches one.
// - Two-slot variant serves both slot values.
// - Claim only indices inside the latched range.
// - Out-of-range access ignored, index read floats.
// - Five or more slots need external decode.
// - Power-down ignores host strobes; bus reset fall still latches straps.
`timescale 1ns/1ps
module idx_port_device #(
   parameter bit TWO_SLOT = 1'b1
) (
   input  wire logic pclk,
   input  wire logic presetn,
   isa_io_if.dev     bus,
   input  wire logic power_down,
   output logic      decode_internal,
   output logic      device_bit,
   output logic      slot_bit
);
   import idx_port_pkg::*;

   logic       rst_fell;
   logic       rd_fell;
   logic       rd_rose;
   logic       wr_fell;
   logic       rd_go;
   logic       wr_go;
   logic       decode_mode_strap_irq_out_n;
   logic       speaker_out_strap_n;
   logic       ring_indicate_out_strap_n;

   logic       internal_ff;
   logic       dev_bit_ff;
   logic       slot_bit_ff;
   logic       pin_rel_ff;
   logic       nxt_internal;
   logic       nxt_dev_bit;
   logic       nxt_slot_bit;
   logic       nxt_pin_rel;

   logic [7:0] index_ff;
   logic [7:0] sd_ff;
   logic       sd_oe_n_ff;
   logic [7:0] nxt_index;
   logic [7:0] nxt_sd;
   logic       nxt_sd_oe_n;

   logic       sel;
   logic       is_data;
   logic       claimed;
   logic       reg_ok;
   logic [5:0] reg_num;
   logic [6:0] mem_addr;
   logic       mem_we;
   logic [7:0] mem [0:MEM_DEPTH-1];

   // Edges of bus reset and the two I/O strobes.
   edge_pulse #(.INIT(1'h0)) u_rst_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .level   (bus.host_bus_reset),
      .fell    (rst_fell),
      .rose    ()
   );

   edge_pulse #(.INIT(1'h1)) u_rd_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .level   (bus.iord_n),
      .fell    (rd_fell),
      .rose    (rd_rose)
   );

   edge_pulse #(.INIT(1'h1)) u_wr_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .level   (bus.iowr_n),
      .fell    (wr_fell),
      .rose    ()
   );

   // In power-down no strobe starts a cycle; the address and data are
   // then never looked at either.
   assign rd_go = rd_fell & ~power_down;
   assign wr_go = wr_fell & ~power_down;

   assign decode_mode_strap_irq_out_n = bus.strap_pin[IRQ_STRAP];
   assign speaker_out_strap_n         = bus.strap_pin[SPK_STRAP];
   assign ring_indicate_out_strap_n   = bus.strap_pin[RING_STRAP];

   // Strap capture at the falling edge of bus reset. Pins are released
   // while bus reset is high so the board pulls set their level.
   always_comb begin
      nxt_internal = internal_ff;
      nxt_dev_bit  = dev_bit_ff;
      nxt_slot_bit = slot_bit_ff;
      nxt_pin_rel  = bus.host_bus_reset;
      if (rst_fell) begin
         nxt_internal = decode_mode_strap_irq_out_n;
         if (TWO_SLOT) begin
            nxt_dev_bit  = ~speaker_out_strap_n;
            nxt_slot_bit = 1'b0;
         end else begin
            nxt_dev_bit  = ~ring_indicate_out_strap_n;
            nxt_slot_bit = ~speaker_out_strap_n;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         internal_ff <= 1'b1;
         dev_bit_ff  <= 1'b0;
         slot_bit_ff <= 1'b0;
         pin_rel_ff  <= 1'b1;
      end else begin
         internal_ff <= nxt_internal;
         dev_bit_ff  <= nxt_dev_bit;
         slot_bit_ff <= nxt_slot_bit;
         pin_rel_ff  <= nxt_pin_rel;
      end
   end

   // The pins carry no function here, so out of reset they sit idle.
   assign bus.strap_o    = PIN_IDLE;
   assign bus.strap_oe_n = {3{pin_rel_ff}};
   assign decode_internal = internal_ff;
   assign device_bit      = dev_bit_ff;
   assign slot_bit        = slot_bit_ff;

   // Port decode. Chip select is required in both modes; internal mode
   // also compares the address so that only the port pair answers.
   assign sel = !bus.aen && !bus.cs_n &&
                (!internal_ff ||
                 bus.sa[15:1] == INDEX_PORT_ADDR[15:1]);
   assign is_data = bus.sa[0] == DATA_PORT_ADDR[0];

   // Range claim: several devices share the ports, so each answers
   // only to its own device bit, and in the one-slot variant its slot bit.
   assign claimed = index_ff[DEV_BIT_POS] == dev_bit_ff &&
                    (TWO_SLOT ||
                     index_ff[SLOT_BIT_POS] == slot_bit_ff);
   assign reg_num = index_ff[REG_NUM_MSB:0];
   assign reg_ok  = reg_num < REGS_PER_SLOT;

   // Slot 1 registers sit above slot 0 in one array.
   assign mem_addr = (TWO_SLOT && index_ff[SLOT_BIT_POS]) ?
                     7'({1'b0, reg_num}) + 7'({1'b0, REGS_PER_SLOT}) :
                     7'({1'b0, reg_num});

   // Access engine. The index is always stored because devices share
   // it; data moves only when this device claims the index.
   always_comb begin
      nxt_index   = index_ff;
      nxt_sd      = sd_ff;
      nxt_sd_oe_n = sd_oe_n_ff;
      mem_we      = 1'b0;
      if (rd_rose || power_down) begin
         nxt_sd_oe_n = 1'b1;
      end
      if (rd_go && sel && claimed) begin
         nxt_sd_oe_n = 1'b0;
         if (is_data) begin
            nxt_sd = reg_ok ? mem[mem_addr] : 8'h00;
         end else begin
            nxt_sd = index_ff;
         end
      end
      if (wr_go && sel) begin
         if (!is_data) begin
            nxt_index = bus.sd;
         end else if (claimed && reg_ok) begin
            mem_we = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         index_ff   <= 8'h00;
         sd_ff      <= 8'h00;
         sd_oe_n_ff <= 1'b1;
      end else begin
         index_ff   <= nxt_index;
         sd_ff      <= nxt_sd;
         sd_oe_n_ff <= nxt_sd_oe_n;
      end
   end

   // Register storage, cleared at reset for a known readback.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < MEM_DEPTH; i++) begin
            mem[i] <= 8'h00;
         end
      end else if (mem_we) begin
         mem[mem_addr] <= bus.sd;
      end
   end

   assign bus.dev_sd_o    = sd_ff;
   assign bus.dev_sd_oe_n = sd_oe_n_ff;
endmodule // idx_port_device

//--- verilog/idx_port_host.sv
// Host end: APB-commanded I/O cycles toward the index port device.
`timescale 1ns/1ps
module idx_port_host (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   isa_io_if.host           bus
);
   import idx_port_pkg::*;

   idx_port_pkg::host_state_t state_ff, nxt_state;

   logic [3:0]  cnt_ff, nxt_cnt;
   logic        wr_ff, nxt_wr;
   logic        pd_ff, nxt_pd;
   logic        brst_ff, nxt_brst;
   logic        ext_ff, nxt_ext;
   logic [7:0]  wdata_ff, nxt_wdata;
   logic [15:0] addr_ff, nxt_addr;
   logic [2:0]  strap_ff, nxt_strap;
   logic [7:0]  rdata_ff, nxt_rdata;
   logic        float_ff, nxt_float;
   logic        wen;
   logic        busy;
   logic        mapped;

   assign wen  = psel && penable && pwrite;
   assign busy = state_ff != H_IDLE;

   // Register writes and the cycle sequencer. A start while busy is
   // dropped, so software polls busy before the next command.
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_wr    = wr_ff;
      nxt_pd    = pd_ff;
      nxt_brst  = brst_ff;
      nxt_ext   = ext_ff;
      nxt_wdata = wdata_ff;
      nxt_addr  = addr_ff;
      nxt_strap = strap_ff;
      nxt_rdata = rdata_ff;
      nxt_float = float_ff;
      if (wen && paddr == CTRL_OFS) begin
         nxt_pd   = pwdata[PD_BIT];
         nxt_brst = pwdata[BRST_BIT];
         nxt_ext  = pwdata[EXT_BIT];
         if (!busy) begin
            nxt_wr    = pwdata[WR_BIT];
            nxt_wdata = pwdata[WDATA_LSB +: 8];
            if (pwdata[GO_BIT]) begin
               nxt_state = H_SETUP;
            end
         end
      end
      if (wen && paddr == ADDR_OFS && !busy) begin
         nxt_addr = pwdata[15:0];
      end
      if (wen && paddr == STRAP_OFS) begin
         nxt_strap = pwdata[2:0];
      end
      unique case (state_ff)
         H_IDLE: begin
         end
         H_SETUP: begin
            nxt_state = H_STROBE;
            nxt_cnt   = IO_STROBE_CYC;
         end
         H_STROBE: begin
            nxt_cnt = cnt_ff - 4'h1;
            if (cnt_ff == 4'h1) begin
               nxt_state = H_HOLD;
               if (!wr_ff) begin
                  nxt_rdata = bus.sd;
                  nxt_float = !bus.sd_driven;
               end
            end
         end
         H_HOLD: begin
            nxt_state = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= H_IDLE;
         cnt_ff   <= 4'h0;
         wr_ff    <= 1'b0;
         pd_ff    <= 1'b0;
         brst_ff  <= BRST_RST;
         ext_ff   <= 1'b0;
         wdata_ff <= 8'h00;
         addr_ff  <= ADDR_RST;
         strap_ff <= STRAP_RST;
         rdata_ff <= 8'h00;
         float_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         wr_ff    <= nxt_wr;
         pd_ff    <= nxt_pd;
         brst_ff  <= nxt_brst;
         ext_ff   <= nxt_ext;
         wdata_ff <= nxt_wdata;
         addr_ff  <= nxt_addr;
         strap_ff <= nxt_strap;
         rdata_ff <= nxt_rdata;
         float_ff <= nxt_float;
      end
   end

   // Bus pins. Chip select stays low outside power-down and external
   // mode; in external mode it plays the outside decoder for the port pair.
   assign bus.sa             = addr_ff;
   assign bus.aen            = 1'b0;
   assign bus.iord_n         = !(state_ff == H_STROBE && !wr_ff);
   assign bus.iowr_n         = !(state_ff == H_STROBE && wr_ff);
   assign bus.host_sd_o      = wdata_ff;
   assign bus.host_sd_oe_n   = !(busy && wr_ff);
   assign bus.host_bus_reset = brst_ff;
   assign bus.strap_pull     = strap_ff;
   assign bus.cs_n = pd_ff ? 1'b1 :
                     (ext_ff && !(busy &&
                      addr_ff[15:1] == INDEX_PORT_ADDR[15:1]));

   // APB read side; zero wait states, unmapped offsets flag an error.
   assign mapped = paddr == CTRL_OFS || paddr == ADDR_OFS ||
                   paddr == RESULT_OFS || paddr == STRAP_OFS;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   always_comb begin
      prdata = 32'h0000_0000;
      unique case (paddr)
         CTRL_OFS: begin
            prdata[WR_BIT]   = wr_ff;
            prdata[PD_BIT]   = pd_ff;
            prdata[BRST_BIT] = brst_ff;
            prdata[EXT_BIT]  = ext_ff;
            prdata[WDATA_LSB +: 8] = wdata_ff;
         end
         ADDR_OFS: prdata[15:0] = addr_ff;
         RESULT_OFS: begin
            prdata[7:0]       = rdata_ff;
            prdata[FLOAT_BIT] = float_ff;
            prdata[BUSY_BIT]  = busy;
         end
         STRAP_OFS: prdata[2:0] = strap_ff;
         default: prdata = 32'h0000_0000;
      endcase
   end
endmodule // idx_port_host

//--- test/idx_port_monitor.sv
// Protocol checker for the host I/O bus joining the index port ends.
`timescale 1ns/1ps
module idx_port_monitor
   import idx_port_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic [15:0] sa,
   input wire logic        aen,
   input wire logic        iord_n,
   input wire logic        iowr_n,
   input wire logic        cs_n,
   input wire logic        host_bus_reset,
   input wire logic        host_sd_oe_n,
   input wire logic [7:0]  dev_sd_o,
   input wire logic        dev_sd_oe_n,
   input wire logic [2:0]  strap_o,
   input wire logic [2:0]  strap_oe_n
);
   // Every property shares the bus clock and is disabled while presetn is low.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Two drivers on the data bus would corrupt both the read and the write.
   a_no_bus_fight: assert property (dev_sd_oe_n || host_sd_oe_n)
      else $error("data bus driven by both ends");
   a_read_width: assert property ($fell(iord_n) |->
      !iord_n [*3] ##1 iord_n) else $error("read strobe width wrong");
   a_write_width: assert property ($fell(iowr_n) |->
      !iowr_n [*3] ##1 iowr_n) else $error("write strobe width wrong");
   a_write_hold: assert property (!iowr_n |->
      !host_sd_oe_n && $stable(sa)) else $error("write data not held");
   a_one_strobe: assert property (iord_n || iowr_n)
      else $error("read and write strobes together");
   a_aen_low: assert property (!aen)
      else $error("address enable raised");
   // Only an address and chip select that mark this device may get a reply.
   a_claim_decode: assert property ($fell(iord_n) &&
      (cs_n || sa[15:1] != INDEX_PORT_ADDR[15:1]) |-> dev_sd_oe_n [*5])
      else $error("device answered a foreign read");
   // The reply is registered, so the fall itself still sees a free bus.
   a_answer_gap: assert property ($fell(iord_n) |-> dev_sd_oe_n)
      else $error("device drove data too early");
   a_drive_window: assert property (!dev_sd_oe_n |->
      !iord_n || !$past(iord_n)) else $error("device drove outside read");
   a_answer_holds: assert property (!dev_sd_oe_n && !iord_n && !cs_n
      |-> ##1 !dev_sd_oe_n) else $error("read data dropped early");
   a_data_stable: assert property (!dev_sd_oe_n && !$past(dev_sd_oe_n)
      |-> $stable(dev_sd_o)) else $error("read data changed");
   // Pins float under bus reset so that the weak board pulls set the level.
   a_strap_free: assert property (host_bus_reset [*2] |->
      strap_oe_n == 3'h7) else $error("strap pins driven in bus reset");
   a_strap_drive: assert property (!host_bus_reset [*3] |->
      strap_oe_n == 3'h0 && strap_o == PIN_IDLE)
      else $error("strap pins not driven idle");
endmodule // idx_port_monitor

//--- test/test_indexed_register_access_port.sv
// Self-checking bench: APB host end driving the index port device end.
`timescale 1ns/1ps
module test_indexed_register_access_port;
   import idx_port_pkg::*;
   logic        pclk       = 1'b0;
   logic        presetn    = 1'b0;
   logic [7:0]  paddr      = 8'h00;
   logic        psel       = 1'b0;
   logic        penable    = 1'b0;
   logic        pwrite     = 1'b0;
   logic [31:0] pwdata     = 32'h0;
   logic        power_down = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        decode_internal;
   logic        device_bit;
   logic        slot_bit;
   logic        one_internal;
   logic        one_device_bit;
   logic        one_slot_bit;
   logic        err;
   logic [31:0] rd;
   logic [31:0] ctrl_mode  = 32'h8; // Bus reset stays high until cleared.
   int          fails      = 0;
   int          n_compared = 0;

   isa_io_if bus_if ();
   idx_port_host u_idx_port_host (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bus(bus_if.host));
   idx_port_device u_idx_port_device (.pclk(pclk), .presetn(presetn),
      .bus(bus_if.dev), .power_down(power_down),
      .decode_internal(decode_internal), .device_bit(device_bit),
      .slot_bit(slot_bit));
   // One-slot variant on a copy of the bus, so both strap decodes run.
   isa_io_if bus_one ();
   assign bus_one.sa             = bus_if.sa;
   assign bus_one.aen            = bus_if.aen;
   assign bus_one.iord_n         = bus_if.iord_n;
   assign bus_one.iowr_n         = bus_if.iowr_n;
   assign bus_one.cs_n           = bus_if.cs_n;
   assign bus_one.host_bus_reset = bus_if.host_bus_reset;
   assign bus_one.host_sd_o      = bus_if.host_sd_o;
   assign bus_one.host_sd_oe_n   = bus_if.host_sd_oe_n;
   assign bus_one.strap_pull     = bus_if.strap_pull;
   idx_port_device #(.TWO_SLOT(1'b0)) u_idx_port_device_one (.pclk(pclk),
      .presetn(presetn), .bus(bus_one.dev), .power_down(power_down),
      .decode_internal(one_internal), .device_bit(one_device_bit),
      .slot_bit(one_slot_bit));
   idx_port_monitor u_idx_port_monitor (.pclk(pclk), .presetn(presetn),
      .sa(bus_if.sa), .aen(bus_if.aen), .iord_n(bus_if.iord_n),
      .iowr_n(bus_if.iowr_n), .cs_n(bus_if.cs_n),
      .host_bus_reset(bus_if.host_bus_reset),
      .host_sd_oe_n(bus_if.host_sd_oe_n), .dev_sd_o(bus_if.dev_sd_o),
      .dev_sd_oe_n(bus_if.dev_sd_oe_n), .strap_o(bus_if.strap_o),
      .strap_oe_n(bus_if.strap_oe_n));

   // Free-running bus clock at 100 MHz.
   always #5 pclk = ~pclk;

   task automatic tally_and_finish();
      $display("Compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk_byte(input string nm, input logic [7:0] e,
                           input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_bit(input string nm, input logic e, input logic g);
      chk_byte(nm, {7'h00, e}, {7'h00, g});
   endtask

   // One APB transfer, started just after an edge. Data is taken at the
   // edge that sees pready high; one idle edge then separates transfers.
   task automatic apb(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      psel    <= 1'b1;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 100) begin
         fails++;
         tally_and_finish();
      end
      q   = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Changing the mode bits waits a few cycles so a strap latch can land.
   task automatic set_mode(input logic [31:0] m);
      ctrl_mode = m;
      apb(CTRL_OFS, 1'b1, m, rd);
      repeat (3) @(posedge pclk);
   endtask

   // One host I/O cycle; the busy flag is polled under a bounded count.
   task automatic io(input logic w, input logic [15:0] a,
                     input logic [7:0] d, output logic [7:0] q,
                     output logic f);
      int n;
      n = 0;
      apb(ADDR_OFS, 1'b1, {16'h0000, a}, rd);
      apb(CTRL_OFS, 1'b1, ctrl_mode | {16'h0000, d, 6'h00, w, 1'b1}, rd);
      do begin
         apb(RESULT_OFS, 1'b0, 32'h0, rd);
         n++;
      end while (rd[BUSY_BIT] !== 1'b0 && n < 20);
      if (rd[BUSY_BIT] !== 1'b0) begin
         fails++;
         tally_and_finish();
      end
      q = rd[7:0];
      f = rd[FLOAT_BIT];
   endtask

   task automatic wr_io(input logic [15:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic       f;
      io(1'b1, a, d, q, f);
   endtask

   // A floated read carries no data, so only the float flag is compared.
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e,
                         input logic ef);
      logic [7:0] q;
      logic       f;
      io(1'b0, a, 8'h00, q, f);
      chk_bit("float", ef, f);
      if (ef === 1'b0) chk_byte("rdata", e, q);
   endtask

   // Watchdog: the whole sequence needs about five hundred cycles.
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      tally_and_finish();
   end

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(STRAP_OFS, 1'b0, 32'h0, rd);
      chk_byte("strap_pull", 8'h07, rd[7:0]);
      apb(8'h10, 1'b0, 32'h0, rd);
      chk_bit("pslverr", 1'b1, err);
      apb(STRAP_OFS, 1'b1, 32'h5, rd);
      set_mode(32'h0);
      chk_bit("decode_internal", 1'b1, decode_internal);
      chk_bit("device_bit", 1'b1, device_bit);
      chk_bit("slot_bit", 1'b0, slot_bit);
      chk_bit("one_device_bit", 1'b0, one_device_bit);
      chk_bit("one_slot_bit", 1'b1, one_slot_bit);
      wr_io(INDEX_PORT_ADDR, 8'h85);
      wr_io(DATA_PORT_ADDR, 8'h5a);
      wr_io(INDEX_PORT_ADDR, 8'hc5);
      wr_io(DATA_PORT_ADDR, 8'ha5);
      rd_chk(INDEX_PORT_ADDR, 8'hc5, 1'b0);
      rd_chk(DATA_PORT_ADDR, 8'ha5, 1'b0);
      wr_io(INDEX_PORT_ADDR, 8'h85);
      rd_chk(DATA_PORT_ADDR, 8'h5a, 1'b0);
      wr_io(INDEX_PORT_ADDR, 8'hb7);
      wr_io(DATA_PORT_ADDR, 8'h33);
      rd_chk(DATA_PORT_ADDR, 8'h33, 1'b0);
      wr_io(INDEX_PORT_ADDR, 8'hb8);
      wr_io(DATA_PORT_ADDR, 8'h77);
      rd_chk(DATA_PORT_ADDR, 8'h00, 1'b0);
      wr_io(INDEX_PORT_ADDR, 8'h05);
      wr_io(DATA_PORT_ADDR, 8'h11);
      rd_chk(DATA_PORT_ADDR, 8'h00, 1'b1);
      rd_chk(INDEX_PORT_ADDR, 8'h00, 1'b1);
      wr_io(INDEX_PORT_ADDR, 8'h85);
      rd_chk(DATA_PORT_ADDR, 8'h5a, 1'b0);
      wr_io(16'h02e1, 8'h22);
      rd_chk(16'h02e1, 8'h00, 1'b1);
      rd_chk(DATA_PORT_ADDR, 8'h5a, 1'b0);
      power_down <= 1'b1;
      wr_io(DATA_PORT_ADDR, 8'h99);
      rd_chk(DATA_PORT_ADDR, 8'h00, 1'b1);
      set_mode(32'h4);
      chk_bit("cs_n", 1'b1, bus_if.cs_n);
      wr_io(DATA_PORT_ADDR, 8'h99);
      rd_chk(DATA_PORT_ADDR, 8'h00, 1'b1);
      power_down <= 1'b0;
      set_mode(32'h0);
      rd_chk(DATA_PORT_ADDR, 8'h5a, 1'b0);
      apb(STRAP_OFS, 1'b1, 32'h4, rd);
      set_mode(32'h18);
      set_mode(32'h10);
      chk_bit("decode_internal", 1'b0, decode_internal);
      chk_bit("device_bit", 1'b1, device_bit);
      wr_io(INDEX_PORT_ADDR, 8'h86);
      wr_io(DATA_PORT_ADDR, 8'h6c);
      rd_chk(DATA_PORT_ADDR, 8'h6c, 1'b0);
      rd_chk(16'h02e1, 8'h00, 1'b1);
      apb(STRAP_OFS, 1'b1, 32'h3, rd);
      set_mode(32'h8);
      set_mode(32'h0);
      chk_bit("decode_internal", 1'b1, decode_internal);
      chk_bit("device_bit", 1'b0, device_bit);
      chk_bit("one_device_bit", 1'b1, one_device_bit);
      chk_bit("one_slot_bit", 1'b0, one_slot_bit);
      wr_io(INDEX_PORT_ADDR, 8'h85);
      rd_chk(DATA_PORT_ADDR, 8'h00, 1'b1);
      wr_io(INDEX_PORT_ADDR, 8'h45);
      wr_io(DATA_PORT_ADDR, 8'h3c);
      rd_chk(DATA_PORT_ADDR, 8'h3c, 1'b0);
      tally_and_finish();
   end
endmodule // test_indexed_register_access_port
